// ---- pfa_pkg.sv ----
// constants shared by the fault a override control block
// ------------------------------------------------------------------
// Operation
// - level bits 13..8 hold pair3 high/low, pair2 high/low, pair1 high/low.
// - on fault a pin goes active if its level bit is 1, else inactive.
// - mode bit 7 set selects cycle-by-cycle fault handling.
// - mode bit clear latches and holds controlled pins at their levels.
// - enable bits 2,1,0 put pairs 3,2,1 under fault control.
// - bits 15..14 and 6..3 read as zero and ignore writes.
// - reset clears all implemented bits, disabling fault control everywhere.
// - second instance has only pair 1; other pair bits have no effect.
// ------------------------------------------------------------------
package pfa_pkg;
    localparam logic [3:0]  FAULT_A_CONTROL_ADDR = 4'h0;
    localparam logic [3:0]  INT_STATUS_ADDR      = 4'h1;
    localparam logic [3:0]  INT_MASK_ADDR        = 4'h2;
    localparam logic [3:0]  LATCH_STATUS_ADDR    = 4'h3;
    localparam int          LEVEL_LSB            = 8;
    localparam int          MODE_BIT             = 7;
    localparam logic [15:0] CONTROL_WRITE_MASK   = 16'h3f87;
    localparam logic [15:0] CONTROL_RESET        = 16'h0000;
    localparam logic [1:0]  INT_RESET            = 2'h0;
    localparam int          NUM_PAIRS            = 3;
endpackage

// ---- pfa_force_pair.sv ----
// one pin pair's forced-output logic
`timescale 1ns/1ps
module pfa_force_pair (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic fault_enable,
    input  wire logic high_level,
    input  wire logic low_level,
    input  wire logic fault_active,
    input  wire logic pwm_high,
    input  wire logic pwm_low,
    output logic      high_output,
    output logic      low_output
);
    logic next_high_output;
    logic next_low_output;

    // --------------------------------------
    // output mux
    // --------------------------------------
    always_comb begin
        next_high_output = pwm_high;
        next_low_output  = pwm_low;
        if (fault_enable && fault_active) begin
            next_high_output = high_level;
            next_low_output  = low_level;
        end
    end

    // registered so pins never glitch on a mux change
    always_ff @(posedge core_clk) begin
        if (reset) begin
            high_output <= 1'b0;
            low_output  <= 1'b0;
        end else begin
            high_output <= next_high_output;
            low_output  <= next_low_output;
        end
    end
endmodule

// ---- pfa_fault_a_control.sv ----
// fault input a control register and forced-output logic
`timescale 1ns/1ps
module pfa_fault_a_control #(
    parameter int PAIRS_PRESENT = 3
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    input  wire logic        fault_a_in,
    input  wire logic        period_boundary,
    input  wire logic        latch_clear,
    input  wire logic [2:0]  pwm_high_in,
    input  wire logic [2:0]  pwm_low_in,
    output logic             pair1_high_output,
    output logic             pair1_low_output,
    output logic             pair2_high_output,
    output logic             pair2_low_output,
    output logic             pair3_high_output,
    output logic             pair3_low_output,
    output logic             fault_active,
    output logic             irq
);
    // --------------------------------------
    // register state
    // --------------------------------------
    logic [15:0] fault_a_control;
    logic [15:0] next_fault_a_control;
    logic [1:0]  int_status;
    logic [1:0]  next_int_status;
    logic [1:0]  int_mask;
    logic [1:0]  next_int_mask;
    logic [15:0] next_reg_rdata;
    logic        latched;
    logic        next_latched;
    logic        cbc_hold;
    logic        next_cbc_hold;
    logic        fault_d;
    logic        next_fault_d;
    logic        next_fault_active;
    logic [2:0]  enable_eff;
    logic [2:0]  high_lv;
    logic [2:0]  low_lv;
    logic [2:0]  hi_out;
    logic [2:0]  lo_out;
    logic        mode_cbc;
    logic        fault_rise;

    // absent pairs drop their enables so their bits do nothing
    function automatic logic [2:0] pair_mask(input int n);
        logic [2:0] m;
        m = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    assign mode_cbc   = fault_a_control[pfa_pkg::MODE_BIT];
    assign enable_eff = fault_a_control[2:0]
                      & pair_mask(PAIRS_PRESENT);
    assign fault_rise = fault_a_in && !fault_d;

    // level bit order: 13=p3h 12=p3l 11=p2h 10=p2l 9=p1h 8=p1l
    generate
        for (genvar g = 0; g < pfa_pkg::NUM_PAIRS; g++) begin : g_lv
            assign high_lv[g] =
                fault_a_control[pfa_pkg::LEVEL_LSB + 2*g + 1];
            assign low_lv[g]  =
                fault_a_control[pfa_pkg::LEVEL_LSB + 2*g];
            pfa_force_pair u_pair (
                .core_clk     (core_clk),
                .reset        (reset),
                .fault_enable (enable_eff[g]),
                .high_level   (high_lv[g]),
                .low_level    (low_lv[g]),
                .fault_active (fault_active),
                .pwm_high     (pwm_high_in[g]),
                .pwm_low      (pwm_low_in[g]),
                .high_output  (hi_out[g]),
                .low_output   (lo_out[g])
            );
        end
    endgenerate

    assign pair1_high_output = hi_out[0];
    assign pair1_low_output  = lo_out[0];
    assign pair2_high_output = hi_out[1];
    assign pair2_low_output  = lo_out[1];
    assign pair3_high_output = hi_out[2];
    assign pair3_low_output  = lo_out[2];
    assign irq = |(int_status & int_mask);

    // --------------------------------------
    // fault sequencing
    // --------------------------------------
    always_comb begin
        next_fault_d  = fault_a_in;
        next_latched  = latched;
        next_cbc_hold = cbc_hold;
        if (mode_cbc) begin
            next_latched = 1'b0;
            if (fault_a_in) begin
                next_cbc_hold = 1'b1;
            end else if (period_boundary) begin
                next_cbc_hold = 1'b0;
            end
        end else begin
            next_cbc_hold = 1'b0;
            // a still-present fault beats the clear
            if (fault_a_in) begin
                next_latched = 1'b1;
            end else if (latch_clear) begin
                next_latched = 1'b0;
            end
        end
        next_fault_active = next_latched || next_cbc_hold;
    end

    // --------------------------------------
    // register access
    // --------------------------------------
    always_comb begin
        next_fault_a_control = fault_a_control;
        next_int_mask        = int_mask;
        next_int_status      = int_status;
        next_reg_rdata       = 16'h0000;
        if (reg_write) begin
            unique case (reg_addr)
                pfa_pkg::FAULT_A_CONTROL_ADDR: begin
                    next_fault_a_control =
                        reg_wdata & pfa_pkg::CONTROL_WRITE_MASK;
                end
                pfa_pkg::INT_STATUS_ADDR: begin
                    next_int_status = int_status & ~reg_wdata[1:0];
                end
                pfa_pkg::INT_MASK_ADDR: begin
                    next_int_mask = reg_wdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        if (fault_rise) begin
            next_int_status[0] = 1'b1;
        end
        if (next_latched && !latched) begin
            next_int_status[1] = 1'b1;
        end
        if (reg_read) begin
            unique case (reg_addr)
                pfa_pkg::FAULT_A_CONTROL_ADDR: begin
                    next_reg_rdata = fault_a_control;
                end
                pfa_pkg::INT_STATUS_ADDR: begin
                    next_reg_rdata = {14'h0000, int_status};
                end
                pfa_pkg::INT_MASK_ADDR: begin
                    next_reg_rdata = {14'h0000, int_mask};
                end
                pfa_pkg::LATCH_STATUS_ADDR: begin
                    next_reg_rdata = {14'h0000, cbc_hold, latched};
                end
                default: begin
                    next_reg_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_a_control <= pfa_pkg::CONTROL_RESET;
            int_status      <= pfa_pkg::INT_RESET;
            int_mask        <= pfa_pkg::INT_RESET;
            reg_rdata       <= 16'h0000;
            latched         <= 1'b0;
            cbc_hold        <= 1'b0;
            fault_d         <= 1'b0;
            fault_active    <= 1'b0;
        end else begin
            fault_a_control <= next_fault_a_control;
            int_status      <= next_int_status;
            int_mask        <= next_int_mask;
            reg_rdata       <= next_reg_rdata;
            latched         <= next_latched;
            cbc_hold        <= next_cbc_hold;
            fault_d         <= next_fault_d;
            fault_active    <= next_fault_active;
        end
    end

    // --------------------------------------
    // checks
    // --------------------------------------
    sequence s_force_latch;
        !fault_a_control[pfa_pkg::MODE_BIT] && fault_a_in;
    endsequence

    property p_unimpl_zero;
        @(posedge core_clk) disable iff (reset)
        (fault_a_control & ~pfa_pkg::CONTROL_WRITE_MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented control bits set");

    property p_reset_clear;
        @(posedge core_clk) $past(reset) |-> fault_a_control == 16'h0000;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control not cleared by reset");

    property p_latch_hold;
        @(posedge core_clk) disable iff (reset)
        (latched && !mode_cbc && !latch_clear) |=> latched;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched fault released early");

    property p_latch_set;
        @(posedge core_clk) disable iff (reset)
        s_force_latch |=> fault_active;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("fault did not latch");

    property p_cbc_release;
        @(posedge core_clk) disable iff (reset)
        (mode_cbc && !fault_a_in && period_boundary) |=> !fault_active;
    endproperty
    a_cbc_release: assert property (p_cbc_release)
        else $error("cycle-by-cycle fault not released at boundary");

    property p_cbc_hold;
        @(posedge core_clk) disable iff (reset)
        (mode_cbc && fault_active && !fault_a_in && !period_boundary
         && $stable(mode_cbc)) |=> fault_active;
    endproperty
    a_cbc_hold: assert property (p_cbc_hold)
        else $error("forcing dropped before period boundary");

    property p_level_drive;
        @(posedge core_clk) disable iff (reset)
        (fault_active && enable_eff[0]) |=>
            pair1_high_output == $past(fault_a_control[9]) &&
            pair1_low_output == $past(fault_a_control[8]);
    endproperty
    a_level_drive: assert property (p_level_drive)
        else $error("pair 1 not forced to level bits");

    property p_disabled_pass;
        @(posedge core_clk) disable iff (reset)
        !enable_eff[2] |=> pair3_high_output == $past(pwm_high_in[2]);
    endproperty
    a_disabled_pass: assert property (p_disabled_pass)
        else $error("disabled pair affected by fault");
endmodule

// ---- pfa_fault_src_model.sv ----
// partner model: external fault source and normal pwm generator drive
`timescale 1ns/1ps
// ------------------------------------------------------------------
// model
// ------------------------------------------------------------------
module pfa_fault_src_model (
    input  wire logic       core_clk,
    input  wire logic       fault_req,
    input  wire logic       boundary_req,
    input  wire logic [2:0] drive_high,
    input  wire logic [2:0] drive_low,
    output logic            fault_a_in,
    output logic            period_boundary,
    output logic [2:0]      pwm_high_in,
    output logic [2:0]      pwm_low_in
);
    // known levels from time zero, before the first edge
    initial begin
        fault_a_in      = 1'b0;
        period_boundary = 1'b0;
        pwm_high_in     = 3'h0;
        pwm_low_in      = 3'h0;
    end
    // registered: the pins move just after an edge, like a real source
    always @(posedge core_clk) begin
        fault_a_in      <= fault_req;
        period_boundary <= boundary_req;
        pwm_high_in     <= drive_high;
        pwm_low_in      <= drive_low;
    end
endmodule

// ---- pfa_fault_a_control_tb.sv ----
// self-checking testbench for the fault a override control block
`timescale 1ns/1ps
module pfa_fault_a_control_tb;
    localparam logic [3:0] A_CTL = pfa_pkg::FAULT_A_CONTROL_ADDR;
    localparam logic [3:0] A_STS = pfa_pkg::INT_STATUS_ADDR;
    localparam logic [3:0] A_MSK = pfa_pkg::INT_MASK_ADDR;
    localparam logic [3:0] A_LAT = pfa_pkg::LATCH_STATUS_ADDR;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic        latch_clear = 1'b0;
    logic        fault_req = 1'b0;
    logic        boundary_req = 1'b0;
    logic [2:0]  drive_h = 3'h0;
    logic [2:0]  drive_l = 3'h7;
    logic [15:0] da;
    logic [15:0] db;
    wire  [15:0] rdata_a;
    wire  [15:0] rdata_b;
    wire  [5:0]  pins_a;
    wire  [5:0]  pins_b;
    wire         fa_a;
    wire         irq_a;
    wire         fault_a_in;
    wire         period_boundary;
    wire  [2:0]  pwm_high_in;
    wire  [2:0]  pwm_low_in;
    int          err_total = 0;
    int          num_checks = 0;
    always #50 core_clk = ~core_clk;
    pfa_fault_src_model u_src (
        .core_clk(core_clk), .fault_req(fault_req),
        .boundary_req(boundary_req), .drive_high(drive_h), .drive_low(drive_l),
        .fault_a_in(fault_a_in), .period_boundary(period_boundary),
        .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in));
    pfa_fault_a_control u_dut (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(rdata_a), .fault_a_in(fault_a_in),
        .period_boundary(period_boundary), .latch_clear(latch_clear),
        .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in),
        .pair1_high_output(pins_a[1]), .pair1_low_output(pins_a[0]),
        .pair2_high_output(pins_a[3]), .pair2_low_output(pins_a[2]),
        .pair3_high_output(pins_a[5]), .pair3_low_output(pins_a[4]),
        .fault_active(fa_a), .irq(irq_a));
    // single-pair instance shares every input, so one write hits both
    pfa_fault_a_control #(.PAIRS_PRESENT(1)) u_dut_p1 (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(rdata_b), .fault_a_in(fault_a_in),
        .period_boundary(period_boundary), .latch_clear(latch_clear),
        .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in),
        .pair1_high_output(pins_b[1]), .pair1_low_output(pins_b[0]),
        .pair2_high_output(pins_b[3]), .pair2_low_output(pins_b[2]),
        .pair3_high_output(pins_b[5]), .pair3_low_output(pins_b[4]),
        .fault_active(), .irq());
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        da = rdata_a;
        db = rdata_b;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic set_fault(input logic v);
        @(posedge core_clk);
        fault_req <= v;
    endtask
    task automatic boundary;
        @(posedge core_clk);
        boundary_req <= 1'b1;
        @(posedge core_clk);
        boundary_req <= 1'b0;
    endtask
    function automatic logic [15:0] pk(input logic [2:0] h,
                                       input logic [2:0] l);
        return {10'h000, h[2], l[2], h[1], l[1], h[0], l[0]};
    endfunction
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        #(100 * 3000);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        rd(A_CTL);
        chk(da, 16'h0000);
        chk({10'h000, pins_a}, pk(3'h0, 3'h7));
        wr(A_CTL, 16'hffff);
        rd(A_CTL);
        chk(da, 16'h3f87);
        chk(db, 16'h3f87);
        // read data must drop back to zero one cycle later
        cyc(1);
        chk(rdata_a, 16'h0000);
        rd(4'h7);
        chk(da, 16'h0000);
        // cycle mode, all levels active, one pair enabled at a time
        for (int i = 0; i < 3; i++) begin
            wr(A_CTL, 16'h3f80 | (16'h0001 << i));
            set_fault(1'b1);
            cyc(3);
            chk({10'h000, pins_a}, pk(3'h1 << i, 3'h7));
            chk({10'h000, pins_b}, pk(3'(i == 0), 3'h7));
            set_fault(1'b0);
            cyc(3);
            chk({10'h000, pins_a}, pk(3'h1 << i, 3'h7));
            rd(A_LAT);
            chk(da, 16'h0002);
            boundary();
            cyc(3);
            chk({10'h000, pins_a}, pk(3'h0, 3'h7));
        end
        // latched mode, high pins active and low pins inactive
        wr(A_STS, 16'h0003);
        wr(A_CTL, 16'h3f07 & 16'h2a07);
        set_fault(1'b1);
        set_fault(1'b0);
        cyc(3);
        chk({10'h000, pins_a}, pk(3'h7, 3'h0));
        chk({10'h000, pins_b}, pk(3'h1, 3'h6));
        boundary();
        cyc(3);
        chk({10'h000, pins_a}, pk(3'h7, 3'h0));
        chk({15'h0000, fa_a}, 16'h0001);
        rd(A_LAT);
        chk(da, 16'h0001);
        rd(A_STS);
        chk(da, 16'h0003);
        chk({15'h0000, irq_a}, 16'h0000);
        wr(A_MSK, 16'h0001);
        cyc(1);
        chk({15'h0000, irq_a}, 16'h0001);
        // bit 1 stays set but is masked, so the line must drop
        wr(A_STS, 16'h0001);
        cyc(1);
        chk({15'h0000, irq_a}, 16'h0000);
        wr(A_MSK, 16'h0002);
        cyc(1);
        chk({15'h0000, irq_a}, 16'h0001);
        @(posedge core_clk);
        latch_clear <= 1'b1;
        @(posedge core_clk);
        latch_clear <= 1'b0;
        cyc(3);
        chk({10'h000, pins_a}, pk(3'h0, 3'h7));
        chk({15'h0000, fa_a}, 16'h0000);
        // inverse drive and levels, pair 2 left out of fault control
        @(posedge core_clk);
        drive_h <= 3'h7;
        drive_l <= 3'h0;
        wr(A_CTL, 16'h1505);
        set_fault(1'b1);
        set_fault(1'b0);
        cyc(3);
        chk({10'h000, pins_a}, pk(3'h2, 3'h5));
        chk({10'h000, pins_b}, pk(3'h6, 3'h1));
        // reset in mid-run with a latched fault in place
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(A_CTL);
        chk(da, 16'h0000);
        chk({10'h000, pins_a}, pk(3'h7, 3'h0));
        chk({15'h0000, fa_a}, 16'h0000);
        stop_test();
    end
endmodule
